// ---- common/spt_consts.vh ----
// Register offsets, field positions, mode codes and reset values of the segment player.
// Assumes an 8-bit register address and 32-bit register data.
`ifndef SPT_CONSTS_VH
`define SPT_CONSTS_VH

`define SPT_REG_CTRL      8'h00
`define SPT_REG_SEL       8'h04
`define SPT_REG_STATUS    8'h08
`define SPT_REG_CMD       8'h0C
`define SPT_REG_TBL_IDX   8'h10
`define SPT_REG_SEG_START 8'h14
`define SPT_REG_SEG_END   8'h18
`define SPT_REG_SEG_RATE  8'h1C
`define SPT_REG_MEM_ADDR  8'h20
`define SPT_REG_MEM_DATA  8'h24
`define SPT_REG_SEQ_ENTRY 8'h28
`define SPT_REG_SEQ_LAST  8'h2C
`define SPT_REG_SEG_LAST  8'h30

`define SPT_CTRL_EN       0
`define SPT_CTRL_MODE_LO  1
`define SPT_CTRL_MODE_HI  3
`define SPT_CTRL_EXT      4
`define SPT_CTRL_SEQ      5

`define SPT_CMD_TRIG      0
`define SPT_CMD_NEXT      1

`define SPT_ST_RUN        0
`define SPT_ST_EQUAL      1
`define SPT_ST_REFUSED    2
`define SPT_ST_SEG_LO     8
`define SPT_ST_LVL_LO     16

`define SPT_MODE_AUTO     3'h0
`define SPT_MODE_ARMED    3'h1
`define SPT_MODE_RETRIG   3'h2
`define SPT_MODE_ARM_RETR 3'h3
`define SPT_MODE_SINGLE   3'h4

`define SPT_RST_CTRL      6'h00
`define SPT_RST_SEL       8'h00

`endif

// ---- dv/spt_far_end.sv ----
// Far side of the player: trigger source and sample sink.
// Assumes the bench pulses go_trig or go_next for one cycle; stall holds the sink off.
`default_nettype none
module spt_far_end (
  input  wire logic sys_clk,
  input  wire logic stall,
  input  wire logic go_trig,
  input  wire logic go_next,
  output logic      sample_ready,
  output logic      trig_pin,
  output logic      next_trig_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] tc = 3'h0;
  logic [2:0] nc = 3'h0;
  // Pins are stretched to four cycles so the two-stage synchroniser cannot miss them.
  always @(posedge sys_clk) begin
    tc <= go_trig ? 3'h4 : tc - {2'h0, tc != 3'h0};
    nc <= go_next ? 3'h4 : nc - {2'h0, nc != 3'h0};
    sample_ready <= !stall;
  end
  assign trig_pin      = tc != 3'h0;
  assign next_trig_pin = nc != 3'h0;
endmodule
`default_nettype wire

// ---- dv/spt_seq_chk.sv ----
// Port checker for the segment player.
// Assumes one clock and the register map of the shared constants header.
`include "spt_consts.vh"
`default_nettype none
module spt_seq_chk #(
  parameter DW = 16
) (
  input wire logic          sys_clk,
  input wire logic          resetn,
  input wire logic [7:0]    reg_addr,
  input wire logic [31:0]   reg_wdata,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [31:0]   reg_rdata,
  input wire logic [DW-1:0] sample_data,
  input wire logic          sample_valid,
  input wire logic          sample_ready,
  input wire logic          playing
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic st_rd  = reg_rd && reg_addr == `SPT_REG_STATUS;
  wire logic wo_rd  = reg_rd && (reg_addr == `SPT_REG_CMD || reg_addr == 8'h3C);
  wire logic arm_wr = reg_wr && reg_addr == `SPT_REG_CTRL && reg_wdata[0] && reg_wdata[1]
                      && !reg_wdata[3] && !reg_wdata[5];
  property p_rd_zero;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data set outside a read");
  property p_wo_zero;
    $past(wo_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("write-only or unmapped read not zero");
  property p_run_st;
    $past(st_rd) |-> reg_rdata[0] == $past(playing);
  endproperty
  a_run_st: assert property (p_run_st) else $error("status running bit wrong");
  property p_refused;
    $past(st_rd) && reg_rdata[2] |-> !reg_rdata[0] && !reg_rdata[1];
  endproperty
  a_refused: assert property (p_refused) else $error("refused mode still runs");
  property p_level;
    $past(st_rd) |-> reg_rdata[19:16] <= 4'h8;
  endproperty
  a_level: assert property (p_level) else $error("buffer level above depth");
  property p_hold;
    sample_valid && !sample_ready |=> sample_valid && $stable(sample_data);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled sample changed");
  property p_armed;
    arm_wr && !playing |=> !playing [*2];
  endproperty
  a_armed: assert property (p_armed) else $error("armed mode ran without trigger");
  property p_start;
    $rose(playing) |-> ##[1:3] sample_valid;
  endproperty
  a_start: assert property (p_start) else $error("no sample after start");
  property p_rst;
    $rose(resetn) |-> !playing && !sample_valid && reg_rdata == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  c_run: cover property ($rose(playing));
  c_full: cover property ($past(st_rd) && reg_rdata[19:16] == 4'h8);
  c_refused: cover property ($past(st_rd) && reg_rdata[2]);
endmodule
bind spt_seq spt_seq_chk #(.DW(DW)) u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_data(sample_data),
  .sample_valid(sample_valid), .sample_ready(sample_ready), .playing(playing)
);
`default_nettype wire

// ---- dv/spt_seq_tb_top.sv ----
// Self-checking bench of the segment player.
// Assumes segment 0 holds 16'h1000..1003 and segment 1 holds 16'h2000..2002.
`include "spt_consts.vh"
`default_nettype none
module spt_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        trig_pin, next_trig_pin, sample_valid, sample_ready, playing;
  logic        stall = 1'b0, go_trig = 1'b0, go_next = 1'b0;
  logic [15:0] sample_data;
  logic [15:0] got[$];
  int          failures = 0, samples_checked = 0, r, s, n;
  always #4 sys_clk = ~sys_clk;
  spt_seq dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_pin(trig_pin),
    .next_trig_pin(next_trig_pin), .sample_data(sample_data), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .playing(playing));
  spt_far_end far (.sys_clk(sys_clk), .stall(stall), .go_trig(go_trig), .go_next(go_next),
    .sample_ready(sample_ready), .trig_pin(trig_pin), .next_trig_pin(next_trig_pin));
  always @(posedge sys_clk)
    if (resetn && sample_valid && sample_ready)
      got.push_back(sample_data);
  task automatic w(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  task automatic ck(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    w(1);
    reg_wr    <= 1'b0;
    w(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    w(1);
    reg_rd   <= 1'b0;
    #1 ck("rdata", e, reg_rdata & m);
    w(1);
  endtask
  task automatic fire(input bit nx);
    go_trig <= !nx;
    go_next <= nx;
    w(1);
    go_trig <= 1'b0;
    go_next <= 1'b0;
    w(1);
  endtask
  // Counts breaks in the stream; a jump to a first sample mid-segment is a restart.
  function automatic int cont(output int rs, output int sw);
    int bad;
    bad = 0;
    rs = 0;
    sw = 0;
    for (int i = 1; i < got.size(); i++)
      if (got[i-1][11:0] == (got[i-1][12] ? 12'h3 : 12'h2)) begin
        if (got[i][11:0] !== 12'h0) bad++;
        if (got[i][15:12] != got[i-1][15:12]) sw++;
      end else if (got[i] !== got[i-1] + 16'h1) begin
        if (got[i][11:0] === 12'h0) rs++;
        else bad++;
      end
    return bad;
  endfunction
  task automatic stop;
    wr(`SPT_REG_CTRL, 32'h0);
    w(24);
    got.delete();
  endtask
  task automatic load;
    wr(`SPT_REG_MEM_ADDR, 32'h0);
    for (int i = 0; i < 7; i++)
      wr(`SPT_REG_MEM_DATA, i < 4 ? 32'h1000 + i : 32'h1FFC + i);
    for (int g = 0; g < 2; g++) begin
      wr(`SPT_REG_TBL_IDX, g);
      wr(`SPT_REG_SEG_START, g * 4);
      wr(`SPT_REG_SEG_END, 3 - g);
      wr(`SPT_REG_SEG_RATE, 32'h1);
    end
    wr(`SPT_REG_SEG_LAST, 32'h1);
    wr(`SPT_REG_SEQ_ENTRY, 32'h201);
    wr(`SPT_REG_SEQ_ENTRY, 32'h10100);
    wr(`SPT_REG_SEQ_LAST, 32'h1);
  endtask
  task automatic t_regs;
    rd(`SPT_REG_CTRL, '1, 32'h0);
    rd(8'h3C, '1, 32'h0);
    wr(`SPT_REG_SEL, 32'h5);
    rd(`SPT_REG_SEL, '1, 32'h5);
    wr(`SPT_REG_SEL, 32'h0);
    wr(`SPT_REG_SEG_RATE, 32'h2);
    wr(`SPT_REG_CTRL, 32'h1);
    w(4);
    rd(`SPT_REG_STATUS, 32'h7, 32'h4);
    rd(`SPT_REG_CTRL, '1, 32'h1);
    wr(`SPT_REG_SEG_RATE, 32'h1);
    w(4);
    rd(`SPT_REG_STATUS, 32'h7, 32'h3);
    rd(`SPT_REG_CMD, '1, 32'h0);
    stop;
  endtask
  task automatic t_auto;
    wr(`SPT_REG_SEL, 32'h0);
    wr(`SPT_REG_CTRL, 32'h1);
    w(9);
    wr(`SPT_REG_CMD, 32'h1);
    wr(`SPT_REG_SEL, 32'h1);
    w(30);
    ck("first", 32'h1000, got[0]);
    ck("gaps", 32'h0, cont(r, s));
    ck("restarts", 32'h0, r);
    ck("switch", 32'h1, s);
    stop;
  endtask
  task automatic t_armed;
    wr(`SPT_REG_SEL, 32'h0);
    wr(`SPT_REG_CTRL, 32'h3);
    w(8);
    ck("idle", 32'h0, got.size());
    wr(`SPT_REG_CMD, 32'h1);
    w(16);
    ck("first", 32'h1000, got[0]);
    wr(`SPT_REG_SEL, 32'h1);
    w(14);
    ck("halt", 32'h0, playing);
    n = got.size();
    w(8);
    ck("held", n, got.size());
    wr(`SPT_REG_CMD, 32'h1);
    w(12);
    ck("new", 32'h2, got[$] >> 12);
    stop;
  endtask
  task automatic t_trig;
    logic [2:0] m[3] = '{`SPT_MODE_SINGLE, `SPT_MODE_RETRIG, `SPT_MODE_ARM_RETR};
    for (int k = 0; k < 3; k++) begin
      wr(`SPT_REG_SEL, 32'h0);
      wr(`SPT_REG_CTRL, {m[k], 1'b1});
      w(6);
      ck("idle", m[k] != `SPT_MODE_ARM_RETR, got.size() != 0);
      repeat (2) begin
        wr(`SPT_REG_CMD, 32'h1);
        w(3);
      end
      if (k == 0)
        repeat (2) begin
          wr(`SPT_REG_CMD, 32'h2);
          w(9);
        end
      w(12);
      ck("gaps", 32'h0, cont(r, s));
      ck("restart", 32'h1, r > 0);
      if (k == 0)
        ck("advance", 32'h2, s);
      stop;
    end
  endtask
  task automatic t_ext;
    wr(`SPT_REG_CTRL, 32'h13);
    w(6);
    ck("idle", 32'h0, got.size());
    fire(1'b0);
    w(12);
    fire(1'b1);
    w(16);
    stall <= 1'b1;
    w(20);
    rd(`SPT_REG_STATUS, 32'hF0000, 32'h80000);
    stall <= 1'b0;
    w(20);
    ck("gaps", 32'h0, cont(r, s));
    ck("advance", 32'h1, s > 0);
    stop;
    rd(`SPT_REG_STATUS, 32'hF0000, 32'h0);
  endtask
  task automatic t_seq;
    wr(`SPT_REG_CTRL, 32'h21);
    w(24);
    for (int i = 0; i < 10; i++)
      ck("seq", i < 6 ? 32'h2000 + i % 3 : 32'h1000 + i - 6, got[i]);
    stop;
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #320000;
    failures++;
    tally_and_finish;
  end
  initial begin
    w(16);
    resetn <= 1'b1;
    w(1);
    load;
    t_regs;
    t_auto;
    t_armed;
    t_trig;
    t_ext;
    t_seq;
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ---- verilog/spt_seq.v ----
// Segment playback controller with its output FIFO.
// Assumes one clock, trigger pins asynchronous to it, and a sink that may stall the stream.
`include "spt_consts.vh"
`default_nettype none

module spt_fifo #(
  parameter W  = 16,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire          sys_clk,
  input  wire          resetn,
  input  wire [W-1:0]  in_data,
  input  wire          in_valid,
  output wire          in_ready,
  output wire [W-1:0]  out_data,
  output wire          out_valid,
  input  wire          out_ready,
  output reg  [AW:0]   level
);
  reg  [W-1:0]  mem [0:D-1];
  reg  [AW-1:0] wp;
  reg  [AW-1:0] rp;
  wire          push = in_valid & in_ready;
  wire          pop  = out_valid & out_ready;

  assign in_ready  = (level != D[AW:0]);
  assign out_valid = (level != {(AW+1){1'b0}});
  assign out_data  = mem[rp];

  always @(posedge sys_clk) begin
    if (!resetn) begin
      wp    <= {AW{1'b0}};
      rp    <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wp] <= in_data;
        wp      <= (wp == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
      end
      if (pop)
        rp <= (rp == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
      if (push & ~pop)
        level <= level + 1'b1;
      else if (pop & ~push)
        level <= level - 1'b1;
    end
  end
endmodule

module spt_seq #(
  parameter DW   = 16,
  parameter AW   = 10,
  parameter SW   = 3,
  parameter NSEG = 8,
  parameter QW   = 3,
  parameter NSEQ = 8,
  parameter FD   = 8,
  parameter FAW  = 3
) (
  input  wire          sys_clk,
  input  wire          resetn,
  input  wire [7:0]    reg_addr,
  input  wire [31:0]   reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [31:0]   reg_rdata,
  input  wire          trig_pin,
  input  wire          next_trig_pin,
  output wire [DW-1:0] sample_data,
  output wire          sample_valid,
  input  wire          sample_ready,
  output wire          playing
);
  reg [DW-1:0] smem      [0:(1<<AW)-1];
  reg [AW-1:0] seg_start [0:NSEG-1];
  reg [AW-1:0] seg_end   [0:NSEG-1];
  reg [7:0]    seg_rate  [0:NSEG-1];
  reg [SW-1:0] seq_seg   [0:NSEQ-1];
  reg [7:0]    seq_rep   [0:NSEQ-1];
  reg          ctrl_en;
  reg [2:0]    trig_mode;
  reg          src_ext;
  reg          seq_mode;
  reg [SW-1:0] seg_sel;
  reg [SW-1:0] seg_last;
  reg [QW-1:0] seq_last;
  reg [SW-1:0] tbl_idx;
  reg [AW-1:0] mem_addr;
  reg          sw_trig;
  reg          sw_next;
  reg          trig_s1, trig_s2, trig_s3;
  reg          next_s1, next_s2, next_s3;
  reg          run;
  reg [SW-1:0] cur_seg;
  reg [AW-1:0] pos;
  reg          pend_next;
  reg          pend_sel;
  reg [QW-1:0] seq_ptr;
  reg [7:0]    rep_cnt;
  reg          rates_equal;
  integer      i;
  // The header keeps the reset select 8 bits wide; only the low SW bits exist here.
  localparam [7:0] RST_SEL = `SPT_RST_SEL;
  wire [FAW:0] fifo_level;
  wire         fifo_in_ready;
  function [SW-1:0] wrap_seg;
    input [SW-1:0] idx;
    input [SW-1:0] last;
    begin
      wrap_seg = (idx == last) ? {SW{1'b0}} : idx + 1'b1;
    end
  endfunction

  function [QW-1:0] wrap_seq;
    input [QW-1:0] idx;
    input [QW-1:0] last;
    begin
      wrap_seq = (idx == last) ? {QW{1'b0}} : idx + 1'b1;
    end
  endfunction
  wire wr_ctrl = reg_wr & (reg_addr == `SPT_REG_CTRL);
  wire wr_sel  = reg_wr & (reg_addr == `SPT_REG_SEL);
  wire wr_cmd  = reg_wr & (reg_addr == `SPT_REG_CMD);
  wire sel_chg = wr_sel & (reg_wdata[SW-1:0] != seg_sel);
  // Rate equality is checked over the populated segments only.
  always @* begin
    rates_equal = 1'b1;
    for (i = 1; i < NSEG; i = i + 1)
      if ((i <= seg_last) && (seg_rate[i] != seg_rate[0]))
        rates_equal = 1'b0;
  end

  wire refused = ctrl_en & ~seq_mode & ~rates_equal;
  wire can_run = ctrl_en & (seq_mode | rates_equal);

  always @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_en   <= 1'b0;
      trig_mode <= `SPT_MODE_AUTO;
      src_ext   <= 1'b0;
      seq_mode  <= 1'b0;
      seg_sel   <= RST_SEL[SW-1:0];
      seg_last  <= {SW{1'b0}};
      seq_last  <= {QW{1'b0}};
      tbl_idx   <= {SW{1'b0}};
      mem_addr  <= {AW{1'b0}};
      sw_trig   <= 1'b0;
      sw_next   <= 1'b0;
    end else begin
      sw_trig <= wr_cmd & reg_wdata[`SPT_CMD_TRIG];
      sw_next <= wr_cmd & reg_wdata[`SPT_CMD_NEXT];
      if (wr_ctrl) begin
        ctrl_en   <= reg_wdata[`SPT_CTRL_EN];
        trig_mode <= reg_wdata[`SPT_CTRL_MODE_HI:`SPT_CTRL_MODE_LO];
        src_ext   <= reg_wdata[`SPT_CTRL_EXT];
        seq_mode  <= reg_wdata[`SPT_CTRL_SEQ];
      end
      if (wr_sel)
        seg_sel <= reg_wdata[SW-1:0];
      if (reg_wr) begin
        case (reg_addr)
          `SPT_REG_TBL_IDX:   tbl_idx <= reg_wdata[SW-1:0];
          `SPT_REG_SEG_START: seg_start[tbl_idx] <= reg_wdata[AW-1:0];
          `SPT_REG_SEG_END:   seg_end[tbl_idx] <= reg_wdata[AW-1:0];
          `SPT_REG_SEG_RATE:  seg_rate[tbl_idx] <= reg_wdata[7:0];
          `SPT_REG_MEM_ADDR:  mem_addr <= reg_wdata[AW-1:0];
          `SPT_REG_MEM_DATA: begin
            smem[mem_addr] <= reg_wdata[DW-1:0];
            mem_addr       <= mem_addr + 1'b1;
          end
          `SPT_REG_SEQ_ENTRY: begin
            seq_seg[reg_wdata[16+QW-1:16]] <= reg_wdata[SW-1:0];
            seq_rep[reg_wdata[16+QW-1:16]] <= reg_wdata[15:8];
          end
          `SPT_REG_SEQ_LAST:  seq_last <= reg_wdata[QW-1:0];
          `SPT_REG_SEG_LAST:  seg_last <= reg_wdata[SW-1:0];
          default: ;
        endcase
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SPT_REG_CTRL:     reg_rdata <= {26'h0, seq_mode, src_ext, trig_mode, ctrl_en};
        `SPT_REG_SEL:      reg_rdata <= {{(32-SW){1'b0}}, seg_sel};
        `SPT_REG_STATUS: begin
          reg_rdata <= 32'h0000_0000;
          reg_rdata[`SPT_ST_RUN]     <= run;
          reg_rdata[`SPT_ST_EQUAL]   <= rates_equal;
          reg_rdata[`SPT_ST_REFUSED] <= refused;
          reg_rdata[`SPT_ST_SEG_LO +: SW]    <= cur_seg;
          reg_rdata[`SPT_ST_LVL_LO +: FAW+1] <= fifo_level;
        end
        `SPT_REG_MEM_ADDR: reg_rdata <= {{(32-AW){1'b0}}, mem_addr};
        `SPT_REG_SEQ_LAST: reg_rdata <= {{(32-QW){1'b0}}, seq_last};
        `SPT_REG_SEG_LAST: reg_rdata <= {{(32-SW){1'b0}}, seg_last};
        default:           reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Pins cross two flip-flops; the third stage only serves edge detection.
  always @(posedge sys_clk) begin
    if (!resetn) begin
      {trig_s1, trig_s2, trig_s3} <= 3'h0;
      {next_s1, next_s2, next_s3} <= 3'h0;
    end else begin
      {trig_s1, trig_s2, trig_s3} <= {trig_pin, trig_s1, trig_s2};
      {next_s1, next_s2, next_s3} <= {next_trig_pin, next_s1, next_s2};
    end
  end

  wire trig_evt = src_ext ? (trig_s2 & ~trig_s3) : sw_trig;
  wire next_evt = src_ext ? (next_s2 & ~next_s3) : sw_next;
  wire is_auto    = (trig_mode == `SPT_MODE_AUTO);
  wire is_armed   = (trig_mode == `SPT_MODE_ARMED);
  wire is_retrig  = (trig_mode == `SPT_MODE_RETRIG);
  wire is_armretr = (trig_mode == `SPT_MODE_ARM_RETR);
  wire is_single  = (trig_mode == `SPT_MODE_SINGLE);
  wire wait_first = is_armed | is_armretr;
  wire restart_ok = is_retrig | is_armretr | is_single | (is_armed & src_ext);
  wire next_ok    = (is_single & ~src_ext) | (is_armed & src_ext);
  wire step   = run & fifo_in_ready;
  wire at_end = (pos == seg_end[cur_seg]);
  wire [7:0] rep_lim = (seq_rep[seq_ptr] == 8'h00) ? 8'h00 : seq_rep[seq_ptr] - 8'h01;

  always @(posedge sys_clk) begin
    if (!resetn) begin
      run       <= 1'b0;
      cur_seg   <= {SW{1'b0}};
      pos       <= {AW{1'b0}};
      pend_next <= 1'b0;
      pend_sel  <= 1'b0;
      seq_ptr   <= {QW{1'b0}};
      rep_cnt   <= 8'h00;
    end else if (!can_run) begin
      run       <= 1'b0;
      pos       <= {AW{1'b0}};
      pend_next <= 1'b0;
      pend_sel  <= 1'b0;
    end else if (!run) begin
      pend_next <= 1'b0;
      pend_sel  <= 1'b0;
      pos       <= {AW{1'b0}};
      if (seq_mode) begin
        run     <= 1'b1;
        seq_ptr <= {QW{1'b0}};
        rep_cnt <= 8'h00;
        cur_seg <= seq_seg[0];
      end else if (!wait_first | trig_evt) begin
        run     <= 1'b1;
        cur_seg <= seg_sel;
      end
    end else if (seq_mode) begin
      if (step) begin
        if (at_end) begin
          pos <= {AW{1'b0}};
          if (rep_cnt >= rep_lim) begin
            rep_cnt <= 8'h00;
            seq_ptr <= wrap_seq(seq_ptr, seq_last);
            cur_seg <= seq_seg[wrap_seq(seq_ptr, seq_last)];
          end else begin
            rep_cnt <= rep_cnt + 8'h01;
          end
        end else begin
          pos <= pos + 1'b1;
        end
      end
    end else if (sel_chg & wait_first) begin
      run <= 1'b0;
    end else if (sel_chg & is_retrig) begin
      cur_seg  <= reg_wdata[SW-1:0];
      pos      <= {AW{1'b0}};
      pend_sel <= 1'b0;
    end else begin
      if (trig_evt & restart_ok) begin
        pos <= {AW{1'b0}};
      end else if (step) begin
        if (at_end) begin
          pos       <= {AW{1'b0}};
          pend_next <= 1'b0;
          pend_sel  <= 1'b0;
          if (pend_next)
            cur_seg <= wrap_seg(cur_seg, seg_last);
          else if (pend_sel)
            cur_seg <= seg_sel;
        end else begin
          pos <= pos + 1'b1;
        end
      end
      // A request landing on the segment's last sample stays pending.
      if (sel_chg & (is_auto | is_single))
        pend_sel <= 1'b1;
      if (next_evt & next_ok)
        pend_next <= 1'b1;
    end
  end

  assign playing = run;
  spt_fifo #(
    .W  (DW),
    .D  (FD),
    .AW (FAW)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_data   (smem[seg_start[cur_seg] + pos]),
    .in_valid  (run),
    .in_ready  (fifo_in_ready),
    .out_data  (sample_data),
    .out_valid (sample_valid),
    .out_ready (sample_ready),
    .level     (fifo_level)
  );
endmodule

`default_nettype wire
